// >>> design/ast_top.sv
// Asynchronous and synchronous serial transceiver with APB register access.
`include "ast_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ast_top
    import ast_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        TX_OR_CLOCK_PIN_I,
    output logic             TX_OR_CLOCK_PIN_O,
    output logic             TX_OR_CLOCK_PIN_OE,
    input  wire logic        RX_OR_DATA_PIN_I,
    output logic             RX_OR_DATA_PIN_O,
    output logic             RX_OR_DATA_PIN_OE
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [8:0] shift_in(input logic [8:0] s, input logic b,
                                            input logic nine);
        shift_in = nine ? {b, s[8:1]} : {1'b0, b, s[7:1]};
    endfunction : shift_in

    ast_ctrl_t   ctrl;
    logic [15:0] baud;
    logic [15:0] brg_cnt;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_cnt;
    logic [8:0]  tx_shift;
    logic        tx_brk;
    logic        tx_line;
    logic        sdir;
    logic        sclk;
    logic        ck_prev;
    logic [8:0]  hold;
    logic        hold_brk;
    logic        hold_full;
    logic        shift_empty;
    ast_txs_t    txs;
    ast_rxs_t    rxs;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_cnt;
    logic [8:0]  rx_shift;
    ast_rx_t     rx_mem [2];
    logic        rx_wp;
    logic        rx_rp;
    logic [1:0]  rx_count;
    logic        overrun;
    logic        brk_seen;
    logic        rx_prev;
    logic        ab_run;
    logic [2:0]  ab_falls;
    logic [19:0] ab_cnt;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    wire        setup    = PSEL & ~PENABLE;
    wire        access   = PSEL & PENABLE & PREADY;
    wire        wr       = access & PWRITE;
    wire        hit_ctrl = PADDR == `AST_OFF_CTRL;
    wire        hit_baud = PADDR == `AST_OFF_BAUD;
    wire        hit_tx   = PADDR == `AST_OFF_TXDATA;
    wire        hit_rx   = PADDR == `AST_OFF_RXDATA;
    wire        hit_st   = PADDR == `AST_OFF_STATUS;
    wire        mapped   = hit_ctrl | hit_baud | hit_tx | hit_rx | hit_st;
    wire        rx_pop   = access & ~PWRITE & hit_rx & (rx_count != 2'd0);
    wire        tx_write = wr & hit_tx & ~hold_full;
    wire        on       = ctrl.enable;
    wire [3:0]  nbits    = ctrl.nine_bit ? 4'd9 : 4'd8;
    wire [31:0] status   = {26'h0, ctrl.auto_baud, brk_seen, overrun, rx_count != 2'd0,
                            shift_empty, ~hold_full};
    wire [31:0] rd_value = hit_ctrl ? {19'h0, ctrl} :
                           hit_baud ? {16'h0, baud} :
                           hit_rx   ? {22'h0, rx_mem[rx_rp]} :
                           hit_st   ? status : 32'h0;

    // ------------------------------------------------------------------------
    // Baud generator: one tick per sixteenth of a bit
    // ------------------------------------------------------------------------
    wire [15:0] div    = ctrl.brg16 ? baud : {8'h00, baud[7:0]};
    wire        tick   = on & (brg_cnt >= div);
    wire        tx_bit = tick & (tx_sub == `AST_LAST_SUB);
    wire        half   = tick & (tx_sub[2:0] == 3'd7);

    // ------------------------------------------------------------------------
    // Synchronous clock edges
    // ------------------------------------------------------------------------
    wire ck_act  = TX_OR_CLOCK_PIN_I ^ ctrl.pol;
    wire s_lead  = ctrl.host ? (half & ~sclk) : (ck_act & ~ck_prev);
    wire s_trail = ctrl.host ? (half & sclk) : (~ck_act & ck_prev);
    wire s_last  = s_trail & (tx_cnt == nbits - 4'd1);
    wire s_go    = ctrl.sync & on & (hold_full & ctrl.tx_en | ctrl.rx_en);

    // ------------------------------------------------------------------------
    // Receive sampling and FIFO push
    // ------------------------------------------------------------------------
    wire       rx_in   = RX_OR_DATA_PIN_I;
    wire       rx_run  = on & ctrl.rx_en & ~ctrl.sync & ~ctrl.auto_baud;
    wire       rx_mid  = tick & (rx_sub == `AST_LAST_SUB);
    wire [8:0] rx_next = shift_in(rx_shift, rx_in, ctrl.nine_bit);
    wire       a_push  = rxs == RX_STOP && rx_mid;
    wire       a_ferr  = ~rx_in;
    wire       a_drop  = ctrl.nine_bit & ctrl.addr_det & ~rx_shift[8];
    wire       s_push  = txs == TX_SYNC && !sdir && s_last;
    wire [8:0] s_data  = shift_in(tx_shift, rx_in, ctrl.nine_bit);
    wire       push    = (a_push & ~a_drop) | s_push;
    wire       full    = rx_count == `AST_RX_DEPTH;
    wire       a_brk   = a_push & a_ferr & (rx_shift == 9'h000);
    wire       rx_fall = rx_prev & ~rx_in;
    wire       ab_done = ab_run & rx_fall & (ab_falls == `AST_ABAUD_FALLS);
    wire [15:0] ab_div = 16'(ab_cnt >> `AST_ABAUD_SHIFT) - 16'h0001;

    // ------------------------------------------------------------------------
    // APB slave: answers in the access phase, one wait-free cycle after setup
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & ~mapped;
            PRDATA  <= setup & ~PWRITE ? rd_value : 32'h0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl <= `AST_CTRL_RST;
            baud <= `AST_BAUD_RST;
        end else begin
            if (wr & hit_ctrl)
                ctrl <= ast_ctrl_t'(PWDATA[`AST_CTRL_W-1:0]);
            else if (ab_done)
                ctrl.auto_baud <= 1'b0;
            if (ab_done)
                baud <= ab_div;
            else if (wr & hit_baud)
                baud <= PWDATA[15:0];
        end
    end

    // ------------------------------------------------------------------------
    // Holding register
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hold      <= 9'h000;
            hold_brk  <= 1'b0;
            hold_full <= 1'b0;
        end else begin
            if (tx_write) begin
                hold      <= {ctrl.ninth & ctrl.nine_bit, PWDATA[7:0]};
                hold_brk  <= ctrl.send_break & ~ctrl.sync;
                hold_full <= 1'b1;
            end else if (txs == TX_LOAD || (txs == TX_IDLE && s_go && hold_full && ctrl.tx_en)) begin
                hold_full <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Baud counter and transmitter sub-bit counter
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            brg_cnt <= 16'h0;
            tx_sub  <= 4'h0;
        end else begin
            brg_cnt <= tick || !on ? 16'h0 : brg_cnt + 16'h1;
            if (txs == TX_IDLE || txs == TX_LOAD)
                tx_sub <= 4'h0;
            else if (tick)
                tx_sub <= tx_sub + 4'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            txs         <= TX_IDLE;
            tx_cnt      <= 4'h0;
            tx_shift    <= 9'h000;
            tx_brk      <= 1'b0;
            tx_line     <= 1'b1;
            shift_empty <= 1'b1;
            sdir        <= 1'b0;
            sclk        <= 1'b0;
        end else begin
            case (txs)
                TX_IDLE: begin
                    tx_line <= 1'b1;
                    sclk    <= 1'b0;
                    tx_cnt  <= 4'h0;
                    if (s_go) begin
                        sdir        <= hold_full & ctrl.tx_en;
                        tx_shift    <= hold_full & ctrl.tx_en ? hold : 9'h000;
                        shift_empty <= ~(hold_full & ctrl.tx_en);
                        txs         <= TX_SYNC;
                    end else if (on & ctrl.tx_en & ~ctrl.sync & hold_full) begin
                        txs <= TX_LOAD;
                    end
                end
                TX_LOAD: begin
                    tx_shift    <= hold;
                    tx_brk      <= hold_brk;
                    shift_empty <= 1'b0;
                    tx_line     <= 1'b0;
                    txs         <= TX_START;
                end
                TX_START: begin
                    tx_line <= 1'b0;
                    if (tx_bit) begin
                        tx_cnt  <= 4'h1;
                        tx_line <= tx_brk ? 1'b0 : tx_shift[0];
                        txs     <= tx_brk ? TX_BRK : TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bit) begin
                        tx_shift <= tx_shift >> 1;
                        tx_cnt   <= tx_cnt + 4'h1;
                        tx_line  <= tx_cnt == nbits ? 1'b1 : tx_shift[1];
                        if (tx_cnt == nbits)
                            txs <= TX_STOP;
                    end
                end
                TX_BRK: begin
                    tx_line <= 1'b0;
                    if (tx_bit) begin
                        tx_cnt <= tx_cnt + 4'h1;
                        if (tx_cnt == `AST_BREAK_BITS - 4'd1) begin
                            tx_line <= 1'b1;
                            txs     <= TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    tx_line <= 1'b1;
                    if (tx_bit) begin
                        shift_empty <= 1'b1;
                        txs         <= hold_full && ctrl.tx_en ? TX_LOAD : TX_IDLE;
                    end
                end
                TX_SYNC: begin
                    if (ctrl.host && half)
                        sclk <= ~sclk;
                    if (s_trail) begin
                        tx_shift <= sdir ? tx_shift >> 1 : shift_in(tx_shift, rx_in, ctrl.nine_bit);
                        tx_cnt   <= tx_cnt + 4'h1;
                        if (s_last) begin
                            shift_empty <= 1'b1;
                            txs         <= TX_IDLE;
                        end
                    end
                    if (!on || !ctrl.sync)
                        txs <= TX_IDLE;
                end
                default: txs <= TX_IDLE;
            endcase
            if (!on && txs != TX_SYNC) begin
                txs         <= TX_IDLE;
                shift_empty <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    wire next_ck_o  = ctrl.sync ? sclk ^ ctrl.pol : tx_line ^ ctrl.pol;
    wire next_ck_oe = on & (~ctrl.sync | ctrl.host);
    wire next_dt_oe = on & ctrl.sync & (txs == TX_SYNC) & sdir;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            TX_OR_CLOCK_PIN_O  <= 1'b1;
            TX_OR_CLOCK_PIN_OE <= 1'b0;
            RX_OR_DATA_PIN_O  <= 1'b1;
            RX_OR_DATA_PIN_OE <= 1'b0;
            ck_prev  <= 1'b0;
        end else begin
            TX_OR_CLOCK_PIN_O  <= on ? next_ck_o : 1'b1;
            TX_OR_CLOCK_PIN_OE <= next_ck_oe;
            RX_OR_DATA_PIN_O  <= tx_shift[0];
            RX_OR_DATA_PIN_OE <= next_dt_oe;
            ck_prev  <= ck_act;
        end
    end

    // ------------------------------------------------------------------------
    // Asynchronous receiver
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rxs      <= RX_IDLE;
            rx_sub   <= 4'h0;
            rx_cnt   <= 4'h0;
            rx_shift <= 9'h000;
        end else if (!rx_run) begin
            rxs <= RX_IDLE;
        end else begin
            if (tick)
                rx_sub <= rx_sub + 4'h1;
            case (rxs)
                RX_IDLE: begin
                    rx_sub   <= 4'h0;
                    rx_cnt   <= 4'h0;
                    rx_shift <= 9'h000;
                    if (!rx_in)
                        rxs <= RX_START;
                end
                RX_START: begin
                    if (tick && rx_sub == `AST_MID_SUB) begin
                        rx_sub <= 4'h0;
                        rxs    <= rx_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_mid) begin
                        rx_shift <= rx_next;
                        rx_cnt   <= rx_cnt + 4'h1;
                        if (rx_cnt == nbits - 4'd1)
                            rxs <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_mid)
                        rxs <= RX_IDLE;
                end
                default: rxs <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Two-entry receive FIFO; a character arriving while full is lost
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_mem[0] <= '0;
            rx_mem[1] <= '0;
            rx_wp     <= 1'b0;
            rx_rp     <= 1'b0;
            rx_count  <= 2'd0;
        end else begin
            if (push && !full) begin
                rx_mem[rx_wp] <= s_push ? ast_rx_t'{1'b0, s_data} : ast_rx_t'{a_ferr, rx_shift};
                rx_wp         <= ~rx_wp;
            end
            if (rx_pop)
                rx_rp <= ~rx_rp;
            rx_count <= rx_count + {1'b0, push & ~full} - {1'b0, rx_pop};
        end
    end

    // ------------------------------------------------------------------------
    // Sticky flags: a set in the cycle of a clear wins
    // ------------------------------------------------------------------------
    wire clr_ov  = wr & hit_st & PWDATA[`AST_ST_OVERRUN];
    wire clr_brk = wr & hit_st & PWDATA[`AST_ST_BREAK];

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            overrun  <= 1'b0;
            brk_seen <= 1'b0;
        end else begin
            overrun  <= (push & full) | (overrun & ~clr_ov);
            brk_seen <= (a_brk & ctrl.wake_en) | (brk_seen & ~clr_brk);
        end
    end

    // ------------------------------------------------------------------------
    // Auto-baud: clocks from first to fifth falling edge span eight bits
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_prev  <= 1'b1;
            ab_run   <= 1'b0;
            ab_falls <= 3'd0;
            ab_cnt   <= 20'h0;
        end else begin
            rx_prev <= rx_in;
            if (!ctrl.auto_baud || !on || ab_done) begin
                ab_run <= 1'b0;
            end else if (rx_fall && !ab_run) begin
                ab_run   <= 1'b1;
                ab_falls <= 3'd0;
                ab_cnt   <= 20'h1;
            end else if (ab_run) begin
                ab_cnt <= ab_cnt + 20'h1;
                if (rx_fall)
                    ab_falls <= ab_falls + 3'd1;
            end
        end
    end

endmodule : ast_top

`default_nettype wire

// >>> design/ast_defs.svh
// Offsets, field positions, reset values and timing counts of the serial transceiver.
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define AST_OFF_CTRL   12'h000
`define AST_OFF_BAUD   12'h004
`define AST_OFF_TXDATA 12'h008
`define AST_OFF_RXDATA 12'h00c
`define AST_OFF_STATUS 12'h010

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define AST_CTRL_W     13
`define AST_ST_HOLD_EMPTY 0
`define AST_ST_SHIFT_EMPTY 1
`define AST_ST_RX_AVAIL 2
`define AST_ST_OVERRUN 3
`define AST_ST_BREAK   4
`define AST_ST_ABAUD   5
`define AST_RX_FERR    9
`define AST_BAUD_RST   16'h000c
`define AST_CTRL_RST   13'h0000

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define AST_OVERSAMPLE 5'd16
`define AST_MID_SUB    4'd7
`define AST_LAST_SUB   4'd15
`define AST_BREAK_BITS 4'd13
`define AST_ABAUD_FALLS 3'd3
`define AST_ABAUD_SHIFT 7
`define AST_RX_DEPTH   2'd2

`endif

// >>> design/ast_pkg.sv
// Types shared by the serial transceiver.
package ast_pkg;

    // ------------------------------------------------------------------------
    // Control word, written by software in one piece
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic wake_en;
        logic auto_baud;
        logic send_break;
        logic brg16;
        logic pol;
        logic addr_det;
        logic ninth;
        logic nine_bit;
        logic host;
        logic sync;
        logic rx_en;
        logic tx_en;
        logic enable;
    } ast_ctrl_t;

    typedef struct packed {
        logic       ferr;
        logic [8:0] data;
    } ast_rx_t;

    typedef enum {TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_BRK, TX_STOP, TX_SYNC} ast_txs_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rxs_t;

endpackage : ast_pkg

// >>> verif/ast_top_sva.sv
// Assertions on the APB pins and the transmit/clock pin of the transceiver top.
`timescale 1ns/1ps
`default_nettype none
module ast_top_sva (
    input  wire logic        SYS_CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR,
    input  wire logic        TX_OR_CLOCK_PIN_O,
    input  wire logic        TX_OR_CLOCK_PIN_OE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    wire logic setup = PSEL && !PENABLE;
    chk_ready_follows: assert property (setup |=> PREADY)
        else $error("ready missing after setup");
    chk_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_ready_cause: assert property (PREADY |-> $past(setup))
        else $error("ready without setup");
    chk_err_unmapped: assert property (setup && PADDR > 12'h010 |=> PSLVERR)
        else $error("no error on unmapped address");
    chk_err_mapped: assert property (setup && PADDR[1:0] == 2'b00 && PADDR <= 12'h010 |=> !PSLVERR)
        else $error("error on mapped address");
    chk_err_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error outside access or with data");
    chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside access");
    chk_start_hold: assert property (TX_OR_CLOCK_PIN_OE && $fell(TX_OR_CLOCK_PIN_O) |-> !TX_OR_CLOCK_PIN_O [*8])
        else $error("space level too short");
    chk_reset_mark: assert property ($rose(RESET_N) |-> TX_OR_CLOCK_PIN_O && !TX_OR_CLOCK_PIN_OE)
        else $error("line not at mark after reset");
endmodule : ast_top_sva
`default_nettype wire

// >>> verif/ast_far_end.sv
// Remote serial transceiver model facing the serial pins.
`timescale 1ns/1ps
`default_nettype none
module ast_far_end #(
    parameter int BIT = 32
) (
    input  wire logic       clk,
    input  wire logic       line_in,
    output logic            line_out,
    output logic [7:0]      got,
    output int              cnt
);
    initial begin
        line_out = 1'b1;
        cnt = 0;
        forever begin
            @(negedge line_in);
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk);
                got[i] = line_in;
            end
            repeat (BIT) @(posedge clk);
            if (line_in) cnt++;
        end
    end
    // A bad stop is cut short so the receiver cannot take its tail for a start.
    task automatic send(input logic [7:0] d, input logic stop);
        @(posedge clk);
        line_out <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk);
            line_out <= (i < 8) ? d[i] : stop;
        end
        repeat (stop ? BIT : BIT * 3 / 4) @(posedge clk);
        line_out <= 1'b1;
    endtask : send
endmodule : ast_far_end
`default_nettype wire

// >>> verif/async_serial_transceiver_test.sv
// Self-checking bench: APB register access and serial traffic against a far-end model.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, a, b) begin checks_done++; if ((b) !== (a)) begin n_errors++; \
    $display("Error %s expected %h seen %h", n, a, b); end end
module async_serial_transceiver_test import ast_pkg::*;;
    logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0, prdata, q;
    logic        pready, pslverr, tx_line, rx_line, e;
    logic [7:0]  got;
    int          cnt, n_errors = 0, checks_done = 0;
    ast_top ast_top_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TX_OR_CLOCK_PIN_I(1'b0), .TX_OR_CLOCK_PIN_O(tx_line), .TX_OR_CLOCK_PIN_OE(), .RX_OR_DATA_PIN_I(rx_line),
        .RX_OR_DATA_PIN_O(), .RX_OR_DATA_PIN_OE());
    // Baud value 1 with the short divider gives 16 * 2 clocks a bit.
    ast_far_end #(.BIT(32)) ast_far_end_inst (.clk(sys_clk), .line_in(tx_line),
        .line_out(rx_line), .got(got), .cnt(cnt));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1) n_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wait_chars(input int n);
        for (int i = 0; i < 5000 && cnt < n; i++) @(posedge sys_clk);
        if (cnt < n) n_errors++;
    endtask : wait_chars
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        apb(1'b0, 12'h004, 32'h0); `CHECK("baud reset", 32'h0000000c, q)
        apb(1'b0, 12'h010, 32'h0); `CHECK("status reset", 32'h00000003, q)
        apb(1'b0, 12'h020, 32'h0); `CHECK("unmapped", 33'h100000000, {e, q})
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h000, 32'h7);
        $display("test registers done");
        apb(1'b1, 12'h008, 32'ha5);
        apb(1'b1, 12'h008, 32'h5a);
        apb(1'b0, 12'h010, 32'h0); `CHECK("tx busy", 2'b00, q[1:0])
        wait_chars(1); `CHECK("tx char", 8'ha5, got)
        wait_chars(2); `CHECK("tx queued", 8'h5a, got)
        apb(1'b1, 12'h008, 32'hc3);
        wait_chars(3); `CHECK("tx back to back", 8'hc3, got)
        $display("test transmit done");
        ast_far_end_inst.send(8'h3c, 1'b1);
        apb(1'b0, 12'h00c, 32'h0); `CHECK("rx char", 32'h0000003c, q)
        ast_far_end_inst.send(8'h81, 1'b0);
        apb(1'b0, 12'h00c, 32'h0); `CHECK("rx framing", 32'h00000281, q)
        for (int k = 0; k < 3; k++) ast_far_end_inst.send(8'h11, 1'b1);
        apb(1'b0, 12'h010, 32'h0); `CHECK("overrun", 2'b11, q[3:2])
        apb(1'b1, 12'h000, 32'h1007);
        ast_far_end_inst.send(8'h00, 1'b0);
        apb(1'b0, 12'h010, 32'h0); `CHECK("break wake", 1'b1, q[4])
        $display("test receive done");
        apb(1'b1, 12'h004, 32'h5);
        apb(1'b1, 12'h000, 32'h807);
        ast_far_end_inst.send(8'h55, 1'b1);
        apb(1'b0, 12'h004, 32'h0); `CHECK("auto baud", 32'h00000001, q)
        apb(1'b1, 12'h000, 32'h107);
        @(posedge sys_clk);
        `CHECK("invert idle", 1'b0, tx_line)
        $display("test line options done");
        give_verdict();
    end
endmodule : async_serial_transceiver_test
bind ast_top ast_top_sva ast_top_sva_inst (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_OR_CLOCK_PIN_O(TX_OR_CLOCK_PIN_O), .TX_OR_CLOCK_PIN_OE(TX_OR_CLOCK_PIN_OE));
`default_nettype wire
